// [hw/mpd_defs.svh]
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: Included by the sequencer and top design files of the diagnostic control block.
// Notes: Definitions only.
`ifndef MPD_DEFS_SVH
`define MPD_DEFS_SVH
`define MPD_ADDR_W          4
`define MPD_OFF_BALANCE     4'h0
`define MPD_OFF_MEASURE     4'h1
`define MPD_OFF_DIAG_CFG    4'h2
`define MPD_OFF_SCAN_CTRL   4'h3
`define MPD_OFF_CELL_SRC    4'h4
`define MPD_OFF_TEST_CUR    4'h5
`define MPD_OFF_STATUS      4'h6
`define MPD_OFF_STATUS_CLR  4'h7
`define MPD_OFF_ROUTE       4'h8
`define MPD_ODD_PATTERN     12'h555
`define MPD_EVEN_PATTERN    12'haaa
`define MPD_DIAG_ODD        3'h5
`define MPD_DIAG_EVEN       3'h6
`define MPD_CFG_ALT_BIT     0
`define MPD_SCAN_POL_BIT    0
`define MPD_SCAN_START_BIT  1
`define MPD_TC_CODE_LSB     0
`define MPD_TC_DIR_BIT      4
`define MPD_TC_OUT_EN_BIT   5
`define MPD_TC_SINGLE_BIT   6
`define MPD_TC_BUS_BIT      7
`define MPD_TC_AUX_LSB      8
`define MPD_ST_LIVE_BIT     11
`define MPD_ST_LATCH_BIT    12
`define MPD_RST_ZERO16      16'h0000
`define MPD_PUMP_TIME_US    200
`define MPD_CLK_MHZ         100
`define MPD_PUMP_CYCLES     (`MPD_PUMP_TIME_US * `MPD_CLK_MHZ)
`endif

// [hw/mpd_pkg.sv]
// Purpose: Types shared by the diagnostic control files.
// Assumes: Nothing beyond the defs header.
// Notes: States of the shutdown recovery sequencer.
package mpd_pkg;
    typedef enum logic [1:0] {
        MPD_RUN,
        MPD_DOWN,
        MPD_PUMP
    } mpd_shdn_state_t;
    typedef logic [15:0] mpd_word_t;
endpackage

// [hw/mpd_field_reg.sv]
// Purpose: One writable register field with a reset to zero.
// Assumes: Write strobe already decoded to this field.
// Notes: Reset value zero keeps every test source off.
`timescale 1ns/1ps
`default_nettype none
module mpd_field_reg #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    // Write side
    input  wire logic         i_we,
    input  wire logic [W-1:0] i_wdata,
    // Stored value
    output logic      [W-1:0] o_q
);
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= '0;
        end else if (i_we) begin
            o_q <= i_wdata;
        end
    end
endmodule // mpd_field_reg
`default_nettype wire

// [hw/mpd_shdn_seq.sv]
// Purpose: Shutdown alert flags and charge pump recovery timing.
// Assumes: Shutdown comparator levels arrive synchronous to the clock.
// Notes: The latched alert survives recovery until software clears it.
`timescale 1ns/1ps
`default_nettype none
`include "mpd_defs.svh"
module mpd_shdn_seq #(
    parameter int PUMP_CYCLES = `MPD_PUMP_CYCLES
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    // Shutdown input comparators
    input  wire logic i_shdn_below_low,
    input  wire logic i_shdn_above_high,
    // Software events
    input  wire logic i_latch_read,
    input  wire logic i_latch_clear,
    // Flags and analog controls
    output logic      o_alert_latched,
    output logic      o_alert_live,
    output logic      o_regulator_en,
    output logic      o_charge_pump_en
);
    import mpd_pkg::*;
    localparam int CW = $clog2(PUMP_CYCLES + 1);
    mpd_shdn_state_t state_reg;
    mpd_shdn_state_t state_next;
    logic [CW-1:0]   cnt_reg;
    logic [CW-1:0]   cnt_next;
    logic            latch_next;
    logic            live_next;
    wire logic       pump_done = (cnt_reg == CW'(PUMP_CYCLES - 1));

    // Set wins over a clear in the same cycle.
    assign latch_next = i_shdn_below_low | (o_alert_latched & ~i_latch_clear);
    assign live_next  = i_shdn_below_low | (o_alert_live & ~i_shdn_above_high);

    always_comb begin
        state_next = state_reg;
        cnt_next   = '0;
        case (state_reg)
            MPD_RUN: begin
                if (i_shdn_below_low) begin
                    state_next = MPD_DOWN;
                end
            end
            MPD_DOWN: begin
                if (i_latch_read && o_alert_latched) begin
                    state_next = MPD_PUMP;
                end
            end
            MPD_PUMP: begin
                cnt_next = cnt_reg + CW'(1);
                if (pump_done || i_shdn_above_high) begin
                    state_next = MPD_RUN;
                    cnt_next   = '0;
                end
            end
            default: begin
                state_next = MPD_RUN;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg       <= MPD_RUN;
            cnt_reg         <= '0;
            o_alert_latched <= 1'b0;
            o_alert_live    <= 1'b0;
        end else begin
            state_reg       <= state_next;
            cnt_reg         <= cnt_next;
            o_alert_latched <= latch_next;
            o_alert_live    <= live_next;
        end
    end

    // Regulator stays off from the low detect until the pump has finished.
    assign o_regulator_en   = (state_reg == MPD_RUN);
    assign o_charge_pump_en = (state_reg == MPD_PUMP);
endmodule // mpd_shdn_seq
`default_nettype wire

// [hw/mpd_diag_ctrl.sv]
// Purpose: Measurement path self-test control registers and source enables.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes: Analog sources, scan sequencer and serial protocol live elsewhere.
//
// How it works
// - Upper measure enables zero drop aux channels.
// - Alternate path bit routes cells alternately.
// - Fifteen input sources, each individually enabled.
// - One four-bit code sets input magnitude.
// - One bit sets source or sink direction.
// - One bit enables both output sources.
// - Same code sets output source magnitude.
// - Default both buses; single mode uses one.
// - Bus select one picks odd source.
// - Even inputs and ground go even bus.
// - Shutdown low sets latched alert, regulator off.
// - Reading latched alert starts pump, regulator back.
// - Live alert clears when shutdown rises.
// - Alternate path latched at measurement start.
`timescale 1ns/1ps
`default_nettype none
`include "mpd_defs.svh"
module mpd_diag_ctrl #(
    parameter int CELLS       = 12,
    parameter int PUMP_CYCLES = `MPD_PUMP_CYCLES
) (
    // Clock and reset
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_n,
    // Register port
    input  wire logic [`MPD_ADDR_W-1:0]  i_addr,
    input  wire mpd_pkg::mpd_word_t      i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output mpd_pkg::mpd_word_t           o_rdata,
    // Scan sequencer handshake
    input  wire logic                    i_scan_busy,
    // Shutdown comparators
    input  wire logic                    i_shdn_below_low,
    input  wire logic                    i_shdn_above_high,
    // Balancing and scan controls
    output logic [CELLS-1:0]             o_balance_switch_enables,
    output logic [14:0]                  o_channel_measure_enables,
    output logic                         o_scan_start,
    output logic                         o_bipolar_mode,
    output logic                         o_alt_path_active,
    // Test current sources
    output logic [CELLS:0]               o_cell_source_enables,
    output logic [1:0]                   o_aux_source_enables,
    output logic [3:0]                   o_test_current_code,
    output logic                         o_test_current_direction,
    output logic                         o_even_bus_source_en,
    output logic                         o_odd_bus_source_en,
    output logic [CELLS+3:0]             o_input_on_odd_bus,
    // Shutdown recovery
    output logic                         o_regulator_en,
    output logic                         o_charge_pump_en
);
    import mpd_pkg::*;

    mpd_word_t balance_q;
    mpd_word_t measure_q;
    mpd_word_t cfg_q;
    mpd_word_t scan_q;
    mpd_word_t cell_src_q;
    mpd_word_t tc_q;
    mpd_word_t rdata_next;
    logic      alt_path_reg;
    logic      start_reg;
    logic      alert_latched;
    logic      alert_live;

    wire logic hit_balance  = (i_addr == `MPD_OFF_BALANCE);
    wire logic hit_measure  = (i_addr == `MPD_OFF_MEASURE);
    wire logic hit_cfg      = (i_addr == `MPD_OFF_DIAG_CFG);
    wire logic hit_scan     = (i_addr == `MPD_OFF_SCAN_CTRL);
    wire logic hit_cell_src = (i_addr == `MPD_OFF_CELL_SRC);
    wire logic hit_tc       = (i_addr == `MPD_OFF_TEST_CUR);
    wire logic hit_status   = (i_addr == `MPD_OFF_STATUS);
    wire logic hit_st_clr   = (i_addr == `MPD_OFF_STATUS_CLR);
    wire logic hit_route    = (i_addr == `MPD_OFF_ROUTE);

    // All fields reset to zero, so no test current flows after reset.
    mpd_field_reg #(.W(16)) u_balance (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_we       (i_wr & hit_balance),
        .i_wdata    (i_wdata),
        .o_q        (balance_q)
    );
    mpd_field_reg #(.W(16)) u_measure (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_we       (i_wr & hit_measure),
        .i_wdata    (i_wdata),
        .o_q        (measure_q)
    );
    mpd_field_reg #(.W(16)) u_cfg (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_we       (i_wr & hit_cfg),
        .i_wdata    (i_wdata),
        .o_q        (cfg_q)
    );
    mpd_field_reg #(.W(16)) u_scan (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_we       (i_wr & hit_scan),
        .i_wdata    (i_wdata),
        .o_q        (scan_q)
    );
    mpd_field_reg #(.W(16)) u_cell_src (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_we       (i_wr & hit_cell_src),
        .i_wdata    (i_wdata),
        .o_q        (cell_src_q)
    );
    mpd_field_reg #(.W(16)) u_tc (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_we       (i_wr & hit_tc),
        .i_wdata    (i_wdata),
        .o_q        (tc_q)
    );

    mpd_shdn_seq #(.PUMP_CYCLES(PUMP_CYCLES)) u_shdn (
        .i_core_clk        (i_core_clk),
        .i_rst_n           (i_rst_n),
        .i_shdn_below_low  (i_shdn_below_low),
        .i_shdn_above_high (i_shdn_above_high),
        .i_latch_read      (i_rd & hit_status),
        .i_latch_clear     (i_wr & hit_st_clr & i_wdata[`MPD_ST_LATCH_BIT]),
        .o_alert_latched   (alert_latched),
        .o_alert_live      (alert_live),
        .o_regulator_en    (o_regulator_en),
        .o_charge_pump_en  (o_charge_pump_en)
    );

    // The switch patterns are software's; the diagnostic code is a readback aid.
    wire logic [2:0] balance_diag_code =
        (balance_q[CELLS-1:0] == `MPD_ODD_PATTERN)  ? `MPD_DIAG_ODD  :
        (balance_q[CELLS-1:0] == `MPD_EVEN_PATTERN) ? `MPD_DIAG_EVEN : 3'h0;

    assign o_balance_switch_enables  = balance_q[CELLS-1:0];
    // Bits above the cell enables gate the aux and block channels.
    assign o_channel_measure_enables = measure_q[14:0];
    assign o_bipolar_mode            = scan_q[`MPD_SCAN_POL_BIT];
    assign o_scan_start              = start_reg;

    // The path is sampled at scan start so a mid-scan write cannot split a cycle.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            alt_path_reg <= 1'b0;
            start_reg    <= 1'b0;
        end else begin
            start_reg <= i_wr & hit_scan & i_wdata[`MPD_SCAN_START_BIT] & ~i_scan_busy;
            if (i_wr && hit_scan && i_wdata[`MPD_SCAN_START_BIT] && !i_scan_busy) begin
                alt_path_reg <= cfg_q[`MPD_CFG_ALT_BIT];
            end
        end
    end
    assign o_alt_path_active = alt_path_reg;

    assign o_cell_source_enables    = cell_src_q[CELLS:0];
    assign o_aux_source_enables     = tc_q[`MPD_TC_AUX_LSB+1:`MPD_TC_AUX_LSB];
    assign o_test_current_code      = tc_q[`MPD_TC_CODE_LSB+3:`MPD_TC_CODE_LSB];
    assign o_test_current_direction = tc_q[`MPD_TC_DIR_BIT];

    wire logic out_en   = tc_q[`MPD_TC_OUT_EN_BIT];
    wire logic single   = tc_q[`MPD_TC_SINGLE_BIT];
    wire logic bus_odd  = tc_q[`MPD_TC_BUS_BIT];
    assign o_even_bus_source_en = out_en & (~single | ~bus_odd);
    assign o_odd_bus_source_en  = out_en & (~single | bus_odd);

    // Bits 0..CELLS are inputs 0..CELLS, then ground, reference, second reference.
    genvar g;
    generate
        for (g = 0; g <= CELLS; g++) begin : g_route
            assign o_input_on_odd_bus[g] = (g % 2) == 1;
        end
    endgenerate
    assign o_input_on_odd_bus[CELLS+1] = 1'b0;
    assign o_input_on_odd_bus[CELLS+2] = 1'b1;
    assign o_input_on_odd_bus[CELLS+3] = 1'b1;

    mpd_word_t status_word;
    assign status_word = 16'(({15'h0, alert_latched} << `MPD_ST_LATCH_BIT)
                       | ({15'h0, alert_live} << `MPD_ST_LIVE_BIT));

    assign rdata_next =
        hit_balance  ? {1'b0, balance_diag_code, balance_q[11:0]} :
        hit_measure  ? measure_q :
        hit_cfg      ? cfg_q :
        hit_scan     ? {scan_q[15:2], i_scan_busy, scan_q[0]} :
        hit_cell_src ? cell_src_q :
        hit_tc       ? tc_q :
        hit_status   ? status_word :
        hit_route    ? o_input_on_odd_bus :
        `MPD_RST_ZERO16;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= `MPD_RST_ZERO16;
        end else begin
            o_rdata <= i_rd ? rdata_next : `MPD_RST_ZERO16;
        end
    end
endmodule // mpd_diag_ctrl
`default_nettype wire

// [test/mpd_diag_ctrl_asserts.sv]
// Purpose: Port-level checks of the diagnostic control block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound into every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
`include "mpd_defs.svh"
module mpd_diag_ctrl_asserts #(
    parameter int CELLS       = 12,
    parameter int PUMP_CYCLES = 8
) (
    // Inputs of the block
    input wire logic                   i_core_clk,
    input wire logic                   i_rst_n,
    input wire logic [`MPD_ADDR_W-1:0] i_addr,
    input wire mpd_pkg::mpd_word_t     i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_shdn_below_low,
    // Outputs of the block
    input wire logic [14:0]            o_channel_measure_enables,
    input wire logic                   o_bipolar_mode,
    input wire logic [CELLS:0]         o_cell_source_enables,
    input wire logic [3:0]             o_test_current_code,
    input wire logic                   o_test_current_direction,
    input wire logic                   o_even_bus_source_en,
    input wire logic                   o_odd_bus_source_en,
    input wire logic [CELLS+3:0]       o_input_on_odd_bus,
    input wire logic                   o_regulator_en,
    input wire logic                   o_charge_pump_en
);
    import mpd_pkg::*;
    logic [15:0] pump_cnt_reg;
    wire logic   tc_wr = i_wr && (i_addr == `MPD_OFF_TEST_CUR);
    // A pump stuck on would drain the supply, so its run length is bounded.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) pump_cnt_reg <= 16'h0000;
        else pump_cnt_reg <= o_charge_pump_en ? pump_cnt_reg + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    code_write_a: assert property (tc_wr |=> o_test_current_code == $past(i_wdata[3:0]))
        else $error("test current code did not follow write");
    dir_write_a: assert property (tc_wr |=> o_test_current_direction == $past(i_wdata[4]))
        else $error("direction did not follow write");
    even_src_a: assert property (tc_wr |=> o_even_bus_source_en ==
        ($past(i_wdata[5]) && !($past(i_wdata[6]) && $past(i_wdata[7]))))
        else $error("even source enable wrong");
    odd_src_a: assert property (tc_wr |=> o_odd_bus_source_en ==
        ($past(i_wdata[5]) && (!$past(i_wdata[6]) || $past(i_wdata[7]))))
        else $error("odd source enable wrong");
    meas_write_a: assert property (i_wr && i_addr == `MPD_OFF_MEASURE
        |=> o_channel_measure_enables == $past(i_wdata[14:0]))
        else $error("measure enables did not follow write");
    src_write_a: assert property (i_wr && i_addr == `MPD_OFF_CELL_SRC
        |=> o_cell_source_enables == $past(i_wdata[CELLS:0]))
        else $error("cell source enables did not follow write");
    pol_write_a: assert property (i_wr && i_addr == `MPD_OFF_SCAN_CTRL
        |=> o_bipolar_mode == $past(i_wdata[0]))
        else $error("polarity did not follow write");
    route_map_a: assert property (o_input_on_odd_bus == 16'hcaaa)
        else $error("bus routing map wrong");
    shdn_reg_a: assert property (i_shdn_below_low |=> !o_regulator_en)
        else $error("regulator on while shutdown low");
    pump_len_a: assert property (pump_cnt_reg <= PUMP_CYCLES)
        else $error("charge pump ran too long");
    pump_end_a: assert property ($fell(o_charge_pump_en) |-> o_regulator_en)
        else $error("regulator off after pump end");
    rst_off_a: assert property ($rose(i_rst_n) |-> o_test_current_code == 4'h0 &&
        !o_even_bus_source_en && !o_odd_bus_source_en && o_cell_source_enables == '0)
        else $error("sources not off after reset");
    cover property (tc_wr);
    cover property ($fell(o_charge_pump_en));
    cover property (i_shdn_below_low);
endmodule // mpd_diag_ctrl_asserts
bind mpd_diag_ctrl mpd_diag_ctrl_asserts #(.CELLS(CELLS), .PUMP_CYCLES(PUMP_CYCLES)) u_asserts (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_shdn_below_low(i_shdn_below_low),
    .o_channel_measure_enables(o_channel_measure_enables), .o_bipolar_mode(o_bipolar_mode),
    .o_cell_source_enables(o_cell_source_enables), .o_test_current_code(o_test_current_code),
    .o_test_current_direction(o_test_current_direction),
    .o_even_bus_source_en(o_even_bus_source_en), .o_odd_bus_source_en(o_odd_bus_source_en),
    .o_input_on_odd_bus(o_input_on_odd_bus), .o_regulator_en(o_regulator_en),
    .o_charge_pump_en(o_charge_pump_en));
`default_nettype wire

// [test/mpd_shdn_pin_model.sv]
// Purpose: Behavioural shutdown pin with its two comparators.
// Assumes: The pump lifts the pin one step a cycle; the host pulls it low.
// Notes: Undriven, the pin keeps its level, as a loaded capacitor would.
`timescale 1ns/1ps
`default_nettype none
module mpd_shdn_pin_model #(
    parameter int RISE = 4
) (
    // Clock and pin drivers
    input  wire logic i_core_clk,
    input  wire logic i_pull_low,
    input  wire logic i_charge_pump_en,
    // Comparator levels
    output logic      o_below_low,
    output logic      o_above_high
);
    int level = RISE;
    always @(posedge i_core_clk) begin
        if (i_pull_low) level <= 0;
        else if (i_charge_pump_en && level < RISE) level <= level + 1;
    end
    assign o_below_low  = (level == 0);
    assign o_above_high = (level == RISE);
endmodule // mpd_shdn_pin_model
`default_nettype wire

// [test/tb_measurement_path_diagnostic_control.sv]
// Purpose: Self-checking bench of the diagnostic control block.
// Assumes: Short pump count so recovery runs in a few cycles.
// Notes: Every scenario judges its own results.
`timescale 1ns/1ps
`default_nettype none
`include "mpd_defs.svh"
module tb_measurement_path_diagnostic_control;
    import mpd_pkg::*;
    logic        clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, busy = 1'b0, pull = 1'b0;
    logic [3:0]  i_addr = 4'h0, code;
    mpd_word_t   i_wdata = 16'h0000, o_rdata, rv, omap;
    logic [11:0] bal;
    logic [14:0] meas;
    logic [12:0] csrc;
    logic [1:0]  aux;
    logic        below, above, start, bip, alt, dir, even, odd, reg_en, pump;
    int          n_mismatch = 0, check_count = 0;
    mpd_diag_ctrl #(.CELLS(12), .PUMP_CYCLES(8)) dut (.i_core_clk(clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_scan_busy(busy), .i_shdn_below_low(below), .i_shdn_above_high(above),
        .o_balance_switch_enables(bal), .o_channel_measure_enables(meas), .o_scan_start(start),
        .o_bipolar_mode(bip), .o_alt_path_active(alt), .o_cell_source_enables(csrc),
        .o_aux_source_enables(aux), .o_test_current_code(code), .o_test_current_direction(dir),
        .o_even_bus_source_en(even), .o_odd_bus_source_en(odd), .o_input_on_odd_bus(omap),
        .o_regulator_en(reg_en), .o_charge_pump_en(pump));
    mpd_shdn_pin_model #(.RISE(4)) u_pin (.i_core_clk(clk), .i_pull_low(pull),
        .i_charge_pump_en(pump), .o_below_low(below), .o_above_high(above));
    initial forever #5 clk = ~clk;
    task automatic chk(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input mpd_word_t d);
        @(posedge clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output mpd_word_t d);
        @(posedge clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic t_reset();
        chk(code === 4'h0 && csrc === 13'h0000 && aux === 2'b00 && !even && !odd, "reset");
        chk(reg_en === 1'b1 && pump === 1'b0 && omap === 16'hcaaa, "map or regulator");
        rd(4'h9, rv);
        chk(rv === 16'h0000, "unmapped read");
        // The host needs this map to tell zero from full-scale open-switch results.
        rd(`MPD_OFF_ROUTE, rv);
        chk(rv === 16'hcaaa, "route map readback");
    endtask
    task automatic t_switch();
        wr(`MPD_OFF_BALANCE, {4'h0, `MPD_ODD_PATTERN});
        rd(`MPD_OFF_BALANCE, rv);
        chk(rv[14:12] === `MPD_DIAG_ODD && bal === 12'h555, "odd pattern");
        wr(`MPD_OFF_BALANCE, {4'h0, `MPD_EVEN_PATTERN});
        rd(`MPD_OFF_BALANCE, rv);
        chk(rv[14:12] === `MPD_DIAG_EVEN && bal === 12'haaa, "even pattern");
        wr(`MPD_OFF_MEASURE, {4'h0, `MPD_EVEN_PATTERN});
        chk(meas === 15'h0aaa, "measure enables");
        wr(`MPD_OFF_BALANCE, 16'h0123);
        rd(`MPD_OFF_BALANCE, rv);
        chk(rv[14:12] === 3'h0, "plain pattern code");
    endtask
    task automatic t_sources();
        mpd_word_t w;
        for (int i = 0; i < 8; i++) begin
            w = {6'h00, 2'(i), 3'(i), 1'(i + 1), 4'(2 * i + 1)};
            wr(`MPD_OFF_TEST_CUR, w);
            chk(code === w[3:0] && dir === w[4] && aux === w[9:8], "source fields");
            chk(even === (w[5] & ~(w[6] & w[7])), "even source");
            chk(odd === (w[5] & (~w[6] | w[7])), "odd source");
        end
        wr(`MPD_OFF_CELL_SRC, 16'hf001);
        chk(csrc === 13'h1001, "cell sources");
    endtask
    task automatic t_scan();
        wr(`MPD_OFF_DIAG_CFG, 16'h0001);
        wr(`MPD_OFF_SCAN_CTRL, 16'h0003);
        chk(start === 1'b1 && alt === 1'b1 && bip === 1'b1, "alternate start");
        wr(`MPD_OFF_DIAG_CFG, 16'h0000);
        chk(alt === 1'b1 && start === 1'b0, "alternate held, start pulse over");
        @(posedge clk);
        busy <= 1'b1;
        wr(`MPD_OFF_SCAN_CTRL, 16'h0003);
        chk(start === 1'b0, "start while busy");
        @(posedge clk);
        busy <= 1'b0;
        wr(`MPD_OFF_SCAN_CTRL, 16'h0003);
        chk(start === 1'b1 && alt === 1'b0, "normal start");
    endtask
    task automatic t_shdn();
        int n;
        @(posedge clk);
        pull <= 1'b1;
        repeat (3) @(posedge clk);
        pull <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(reg_en === 1'b0 && pump === 1'b0, "regulator in shutdown");
        rd(`MPD_OFF_STATUS, rv);
        chk(rv[12] === 1'b1 && rv[11] === 1'b1, "alerts set");
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            #1;
            if (reg_en === 1'b1) break;
        end
        chk(n < 12, "regulator recovery time");
        if (n == 40) return;
        rd(`MPD_OFF_STATUS, rv);
        chk(rv[12] === 1'b1 && rv[11] === 1'b0, "live clear, latch held");
        wr(`MPD_OFF_STATUS_CLR, 16'h1000);
        rd(`MPD_OFF_STATUS, rv);
        chk(rv[12] === 1'b0, "latch cleared");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        i_rst_n <= 1'b1;
        #1;
        t_reset();
        t_switch();
        t_sources();
        t_scan();
        t_shdn();
        final_report();
    end
endmodule // tb_measurement_path_diagnostic_control
`default_nettype wire
